// file: lif_pkg.sv
// Constants for the line interface pins and frame end marker block.
// Assumes one 250 MHz clock and a simple register port from the host bus.
// How it works
// R1: Scan bit 1 shows lock-lost input level
// R2: Low means locked, high means lock lost
// R3: 8-bit bus leaves upper lines idle
// R4: Frame end mark high one bit
// R5: Terminal equipment starts next frame on mark
// R6: Bypass output follows drive bit 5
// R7: Bypass bit held in register, reads back
package lif_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0]  LIF_DRIVE_ADDR   = 8'h72;
  localparam logic [7:0]  LIF_SCAN_ADDR    = 8'h73;
  localparam int          LIF_EQ_BYP_BIT   = 5;
  localparam int          LIF_LOCK_BIT     = 1;
  localparam logic [7:0]  LIF_DRIVE_RESET  = 8'h00;
  localparam logic [7:0]  LIF_DRIVE_MASK   = 8'h20;
  // ----------------------------------------
  // Frame timing
  // ----------------------------------------
  localparam int          LIF_FRAME_BITS   = 4760;
  localparam logic [12:0] LIF_FRAME_LAST   = 13'(LIF_FRAME_BITS - 1);
endpackage : lif_pkg

// file: lif_top.sv
// Line interface scan/drive pins, bypass control and transmit frame end mark.
// Assumes the host bus gives one-cycle read/write strobes with an 8-bit address.
`timescale 1ns/1ns
module lif_top (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        width16,
  input  wire logic        tx_bit_en,
  input  wire logic        recv_lock_lost_in,
  input  wire logic [7:0]  bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [15:0] bus_wdata,
  output logic      [15:0] bus_rdata,
  output logic      [15:0] bus_rdata_oe,
  output logic             eq_bypass_out,
  output logic             tx_frame_end_mark,
  output logic             recv_locked
);
  import lif_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0]  drive_r;
  logic [7:0]  drive_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        rd_oe_r;
  logic        rd_oe_nxt;
  logic [12:0] bitcnt_r;
  logic [12:0] bitcnt_nxt;
  logic        mark_r;
  logic        mark_nxt;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic        wr_drive;
  logic        rd_drive;
  logic        rd_scan;
  logic        last_bit;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction : hit

  assign wr_drive = bus_wr && hit(bus_addr, LIF_DRIVE_ADDR);
  assign rd_drive = bus_rd && hit(bus_addr, LIF_DRIVE_ADDR);
  assign rd_scan  = bus_rd && hit(bus_addr, LIF_SCAN_ADDR);
  // Enable gates the compare, so a stalled bit clock cannot wrap early
  assign last_bit = tx_bit_en && (bitcnt_r == LIF_FRAME_LAST);

  // ----------------------------------------
  // Drive register
  // ----------------------------------------
  always_comb begin
    drive_nxt = drive_r;
    // R6: bit 5 written
    if (wr_drive) begin
      // Unused drive bits dropped, so they read zero
      drive_nxt = bus_wdata[7:0] & LIF_DRIVE_MASK;
    end
  end

  // R7: held between writes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      drive_r <= LIF_DRIVE_RESET;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  // ----------------------------------------
  // Read return
  // ----------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    rd_oe_nxt = bus_rd;
    if (bus_rd) begin
      rdata_nxt = 16'h0000;
      if (rd_drive) begin
        rdata_nxt[7:0] = drive_r;
      end else if (rd_scan) begin
        // R1: live lock-lost level
        rdata_nxt[LIF_LOCK_BIT] = recv_lock_lost_in;
      end
      // R3: upper byte idle in 8-bit mode
      if (!width16) begin
        rdata_nxt[15:8] = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 16'h0000;
      rd_oe_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rd_oe_r <= rd_oe_nxt;
    end
  end

  // ----------------------------------------
  // Frame end mark
  // ----------------------------------------
  // Mark holds until the next bit, so a slow bit clock sees a full bit
  always_comb begin
    bitcnt_nxt = bitcnt_r;
    mark_nxt   = mark_r;
    if (tx_bit_en) begin
      // R4: one bit period high
      mark_nxt   = last_bit;
      bitcnt_nxt = last_bit ? 13'h0000 : bitcnt_r + 13'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bitcnt_r <= 13'h0000;
      mark_r   <= 1'b0;
    end else begin
      bitcnt_r <= bitcnt_nxt;
      mark_r   <= mark_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // R6: pin follows stored bit
  assign eq_bypass_out     = drive_r[LIF_EQ_BYP_BIT];
  // R5: terminal equipment realigns on this
  assign tx_frame_end_mark = mark_r;
  // R2: low input means locked
  assign recv_locked       = ~recv_lock_lost_in;
  assign bus_rdata         = rdata_r;
  // R3: upper lines never driven in 8-bit mode
  assign bus_rdata_oe      = {{8{rd_oe_r & width16}}, {8{rd_oe_r}}};

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_drive_write;
    wr_drive;
  endsequence
  sequence s_drive_read;
    rd_drive;
  endsequence
  sequence s_scan_read;
    rd_scan;
  endsequence
  sequence s_frame_last;
    last_bit;
  endsequence

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_scan;
    @(posedge sys_clk) disable iff (!nrst)
      s_scan_read |=> bus_rdata[LIF_LOCK_BIT] == $past(recv_lock_lost_in);
  endproperty
  a_scan: assert property (p_scan) else $error("scan bit wrong"); // R1

  property p_lock;
    @(posedge sys_clk) disable iff (!nrst)
      recv_locked != recv_lock_lost_in;
  endproperty
  a_lock: assert property (p_lock) else $error("lock sense wrong"); // R2

  property p_upper;
    @(posedge sys_clk) disable iff (!nrst)
      !width16 |-> bus_rdata_oe[15:8] == 8'h00;
  endproperty
  a_upper: assert property (p_upper) else $error("upper lines driven"); // R3

  property p_oe_read;
    @(posedge sys_clk) disable iff (!nrst)
      bus_rd |=> bus_rdata_oe[7:0] == 8'hFF;
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("read not driven"); // R1

  property p_oe_idle;
    @(posedge sys_clk) disable iff (!nrst)
      !bus_rd |=> bus_rdata_oe == 16'h0000;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("bus driven when idle"); // R3

  property p_mark;
    @(posedge sys_clk) disable iff (!nrst)
      mark_r && tx_bit_en |=> !mark_r;
  endproperty
  a_mark: assert property (p_mark) else $error("mark too long"); // R4

  property p_mark_start;
    @(posedge sys_clk) disable iff (!nrst)
      s_frame_last |=> mark_r;
  endproperty
  a_mark_start: assert property (p_mark_start) else $error("mark missing"); // R4

  property p_mark_only;
    @(posedge sys_clk) disable iff (!nrst)
      tx_bit_en && !last_bit |=> !mark_r;
  endproperty
  a_mark_only: assert property (p_mark_only) else $error("stray mark"); // R4

  property p_count;
    @(posedge sys_clk) disable iff (!nrst)
      bitcnt_r <= LIF_FRAME_LAST;
  endproperty
  a_count: assert property (p_count) else $error("bit count out of frame"); // R4

  property p_byp;
    @(posedge sys_clk) disable iff (!nrst)
      s_drive_write |=> eq_bypass_out == $past(bus_wdata[LIF_EQ_BYP_BIT]);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass not updated"); // R6

  property p_hold;
    @(posedge sys_clk) disable iff (!nrst)
      !bus_wr |=> $stable(eq_bypass_out);
  endproperty
  a_hold: assert property (p_hold) else $error("bypass moved"); // R7

  property p_drive_read;
    @(posedge sys_clk) disable iff (!nrst)
      s_drive_read |=> bus_rdata[LIF_EQ_BYP_BIT] == $past(eq_bypass_out)
        && (bus_rdata[7:0] & ~LIF_DRIVE_MASK) == 8'h00;
  endproperty
  a_drive_read: assert property (p_drive_read) else $error("drive read back wrong"); // R7
endmodule : lif_top

// file: lif_far_model.sv
// Far side: line unit lock flag and terminal bit pacing.
// Assumes the framer clock is shared.
`timescale 1ns/1ns
module lif_far_model (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic lost,
  input  wire logic mark,
  output logic      lock_lost_out,
  output logic      bit_en,
  output int        frames
);
  // Line unit lock flag passes straight through
  assign lock_lost_out = lost;
  // Bit every cycle, so mark width is one bit
  assign bit_en = 1'b1;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      frames <= 0;
    end else if (mark) begin
      frames <= frames + 1;
    end
  end
endmodule : lif_far_model

// file: testbench.sv
// Register and frame mark tests for lif_top.
// Assumes lif_pkg and the far side model.
`timescale 1ns/1ns
module testbench;
  import lif_pkg::*;
  logic sys_clk = 0, nrst = 0, w16 = 1, lost = 0, wr = 0, rd = 0;
  logic mk, byp, lk, ten, ll;
  logic [7:0] a = 8'h00;
  logic [15:0] wd = 16'h0000, rdat, oe;
  int miscompares = 0, checks = 0, frames, n;
  lif_far_model far (.sys_clk, .nrst, .lost, .mark(mk), .lock_lost_out(ll), .bit_en(ten),
    .frames);
  lif_top DUT (.sys_clk, .nrst, .width16(w16), .tx_bit_en(ten), .recv_lock_lost_in(ll),
    .bus_addr(a), .bus_wr(wr), .bus_rd(rd), .bus_wdata(wd), .bus_rdata(rdat),
    .bus_rdata_oe(oe), .eq_bypass_out(byp), .tx_frame_end_mark(mk), .recv_locked(lk));
  initial forever #2 sys_clk = ~sys_clk;
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic pins(logic l, logic w);
    @(posedge sys_clk);
    lost <= l;
    w16 <= w;
  endtask : pins
  task automatic acc(logic w, logic [7:0] ad, logic [15:0] d);
    @(posedge sys_clk);
    a <= ad;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge sys_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask : acc
  task automatic gap(output int c);
    c = 0;
    do begin
      @(posedge sys_clk);
      #1;
      c++;
    end while (mk !== 1'b1 && c < 6000);
  endtask : gap
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    lost <= 1'b1;
    acc(1'b0, LIF_SCAN_ADDR, 16'h0000);
    chk("scan", rdat, 16'h0002); // lock lost bit
    chk("oe16", oe, 16'hFFFF); // all lines in 16-bit mode
    chk("locked", {15'h0000, lk}, 16'h0000); // lost means unlocked
    acc(1'b0, 8'h00, 16'h0000);
    chk("unmapped", rdat, 16'h0000); // only scan shows lock
    pins(1'b0, 1'b1);
    acc(1'b0, LIF_SCAN_ADDR, 16'h0000);
    chk("scan", rdat, 16'h0000); // locked reads zero
    chk("locked", {15'h0000, lk}, 16'h0001); // low means locked
    acc(1'b1, LIF_DRIVE_ADDR, 16'hFFFF);
    chk("bypass", {15'h0000, byp}, 16'h0001); // bit 5 high
    acc(1'b0, LIF_DRIVE_ADDR, 16'h0000);
    chk("drive", rdat, 16'h0020); // read back
    acc(1'b1, 8'h00, 16'h0000);
    chk("bypass", {15'h0000, byp}, 16'h0001); // other address ignored
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("bypass", {15'h0000, byp}, 16'h0000); // reset clears bit
    chk("oe", oe, 16'h0000); // nothing driven in reset
    @(posedge sys_clk);
    nrst <= 1'b1;
    acc(1'b1, LIF_DRIVE_ADDR, 16'h0020);
    chk("bypass", {15'h0000, byp}, 16'h0001); // bit 5 high
    acc(1'b1, LIF_DRIVE_ADDR, 16'hFFDF);
    chk("bypass", {15'h0000, byp}, 16'h0000); // bit 5 low
    pins(1'b1, 1'b0);
    acc(1'b0, LIF_SCAN_ADDR, 16'h0000);
    chk("oe8", oe, 16'h00FF); // upper lines idle
    chk("scan8", rdat, 16'h0002); // upper byte zero
    gap(n);
    gap(n);
    chk("period", 16'(n), 16'(LIF_FRAME_BITS)); // one mark a frame
    @(posedge sys_clk);
    #1;
    chk("width", {15'h0000, mk}, 16'h0000); // one bit wide
    chk("frames", 16'(frames), 16'h0002); // next frame on each mark
    wrap_up();
  end
endmodule : testbench
